// File: rtc_cfg.svh
// constants of the clock/calendar register bank
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define RTC_NUM_REGS 18
`define RTC_LAST_ADDR 5'h11
`define RTC_FIRST_ADDR 5'h00

// register addresses
`define RTC_ADDR_CTRL1 5'h00
`define RTC_ADDR_CTRL2 5'h01
`define RTC_ADDR_TRIM 5'h02
`define RTC_ADDR_RAM 5'h03
`define RTC_ADDR_SEC 5'h04
`define RTC_ADDR_MIN 5'h05
`define RTC_ADDR_HOUR 5'h06
`define RTC_ADDR_DAY 5'h07
`define RTC_ADDR_WDAY 5'h08
`define RTC_ADDR_MONTH 5'h09
`define RTC_ADDR_YEAR 5'h0A
`define RTC_ADDR_ALM_FIRST 5'h0B
`define RTC_ADDR_ALM_LAST 5'h0F
`define RTC_ADDR_TMR1 5'h10
`define RTC_ADDR_TMR2 5'h11

// implemented-bit masks
`define RTC_MASK_CTRL1 8'hB7
`define RTC_MASK_CTRL2 8'hDF
`define RTC_MASK_SEC 8'hFF
`define RTC_MASK_MIN 8'h7F
`define RTC_MASK_HOUR 8'h3F
`define RTC_MASK_DAY 8'h3F
`define RTC_MASK_WDAY 8'h07
`define RTC_MASK_MONTH 8'h1F
`define RTC_MASK_ALM_HOUR 8'hBF
`define RTC_MASK_ALM_DAY 8'hBF
`define RTC_MASK_ALM_WDAY 8'h87
`define RTC_MASK_TMR2 8'h1F
`define RTC_MASK_FULL 8'hFF

// reset values
`define RTC_RST_DEFAULT 8'h00
`define RTC_RST_DAY 8'h01
`define RTC_RST_MONTH 8'h01
`define RTC_RST_ALARM 8'h80

// control bit positions
`define RTC_BIT_STOP 5

// BCD limits of the counters
`define RTC_SEC_LAST 7'h59
`define RTC_MIN_LAST 8'h59
`define RTC_HOUR_LAST 8'h23
`define RTC_WDAY_LAST 8'h06
`define RTC_MONTH_LAST 8'h12
`define RTC_YEAR_LAST 8'h99

// crystal and host link timing
`define RTC_XTAL_HZ 32768
`define RTC_XTAL_EDGES_PER_SEC 15'h7FFF
`define RTC_HOST_MAX_BPS 400000
`define RTC_CLOCK_HZ 100000000
`define RTC_HOST_BYTE_CYCLES ((`RTC_CLOCK_HZ / `RTC_HOST_MAX_BPS) * 8)

`endif

// File: rtc_pkg.sv
// types of the clock/calendar register bank
package rtc_pkg;
	typedef logic [7:0] rtc_byte_t;
	typedef logic [4:0] rtc_addr_t;
	typedef logic [14:0] rtc_div_t;
	typedef enum logic [2:0] {
		RTC_PTR_IDLE = 3'b001,
		RTC_PTR_LOAD = 3'b010,
		RTC_PTR_STEP = 3'b100
	} rtc_ptr_op_t;
endpackage

// File: rtc_register_access.sv
// register bank, pointer and BCD time counters of the clock/calendar
`timescale 1ns/100ps
`include "rtc_cfg.svh"

module rtc_register_access
	import rtc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_access_active,
	input wire logic i_ptr_load,
	input wire logic [4:0] i_ptr_value,
	input wire logic i_wr_strobe,
	input wire logic [7:0] i_wr_data,
	input wire logic i_rd_strobe,
	output logic [7:0] o_rd_data,
	output logic [4:0] o_ptr,
	input wire logic i_crystal_in_pin,
	output logic o_crystal_out_pin,
	input wire logic i_clock_out_gate_input,
	output logic o_divided_clock_pin,
	output logic o_divided_clock_oe,
	output logic o_seconds_tick
);

	// implemented bits of each address
	function automatic rtc_byte_t impl_mask(input rtc_addr_t a);
		case (a)
			`RTC_ADDR_CTRL1: impl_mask = `RTC_MASK_CTRL1;
			`RTC_ADDR_CTRL2: impl_mask = `RTC_MASK_CTRL2;
			`RTC_ADDR_MIN: impl_mask = `RTC_MASK_MIN;
			`RTC_ADDR_HOUR: impl_mask = `RTC_MASK_HOUR;
			`RTC_ADDR_DAY: impl_mask = `RTC_MASK_DAY;
			`RTC_ADDR_WDAY: impl_mask = `RTC_MASK_WDAY;
			`RTC_ADDR_MONTH: impl_mask = `RTC_MASK_MONTH;
			5'h0D: impl_mask = `RTC_MASK_ALM_HOUR;
			5'h0E: impl_mask = `RTC_MASK_ALM_DAY;
			`RTC_ADDR_ALM_LAST: impl_mask = `RTC_MASK_ALM_WDAY;
			`RTC_ADDR_TMR2: impl_mask = `RTC_MASK_TMR2;
			default: impl_mask = `RTC_MASK_FULL;
		endcase
	endfunction

	// value loaded at reset
	function automatic rtc_byte_t reset_value(input rtc_addr_t a);
		if (a == `RTC_ADDR_DAY || a == `RTC_ADDR_MONTH) begin
			reset_value = `RTC_RST_DAY;
		end else if (a >= `RTC_ADDR_ALM_FIRST && a <= `RTC_ADDR_ALM_LAST) begin
			reset_value = `RTC_RST_ALARM;
		end else begin
			reset_value = `RTC_RST_DEFAULT;
		end
	endfunction

	// BCD increment, wrapping from last back to first
	function automatic rtc_byte_t bcd_inc(input rtc_byte_t v, input rtc_byte_t last,
			input rtc_byte_t first);
		if (v >= last) begin
			bcd_inc = first;
		end else if (v[3:0] >= 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = v + 8'h01;
		end
	endfunction

	// last day of a month, BCD month and year
	function automatic rtc_byte_t month_last_day(input rtc_byte_t m, input rtc_byte_t y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			8'h02: month_last_day = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_last_day = 8'h30;
			default: month_last_day = 8'h31;
		endcase
	endfunction

	rtc_byte_t regs [0:`RTC_NUM_REGS-1];
	rtc_addr_t ptr;
	rtc_ptr_op_t ptr_op;
	rtc_div_t div_count;
	logic xtal_prev;
	logic tick;
	logic pending;
	logic frozen;
	logic apply;
	logic running;
	rtc_byte_t next_sec;
	rtc_byte_t next_min;
	rtc_byte_t next_hour;
	rtc_byte_t next_day;
	rtc_byte_t next_wday;
	rtc_byte_t next_month;
	rtc_byte_t next_year;
	logic c_sec;
	logic c_min;
	logic c_hour;
	logic c_day;
	logic c_month;

	// pointer operation; a load outranks a byte step
	always_comb begin
		if (i_ptr_load) begin
			ptr_op = RTC_PTR_LOAD;
		end else if (i_wr_strobe || i_rd_strobe) begin
			ptr_op = RTC_PTR_STEP;
		end else begin
			ptr_op = RTC_PTR_IDLE;
		end
	end

	// register address pointer
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr <= `RTC_FIRST_ADDR;
		end else begin
			case (ptr_op)
				RTC_PTR_LOAD: begin
					ptr <= (i_ptr_value > `RTC_LAST_ADDR) ? `RTC_FIRST_ADDR : i_ptr_value;
				end
				RTC_PTR_STEP: begin
					ptr <= (ptr == `RTC_LAST_ADDR) ? `RTC_FIRST_ADDR : ptr + 5'h01;
				end
				RTC_PTR_IDLE: begin
					ptr <= ptr;
				end
				default: begin
					ptr <= `RTC_FIRST_ADDR;
				end
			endcase
		end
	end

	assign o_ptr = ptr;

	// crystal edge divider; one second is 32768 rising edges
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			xtal_prev <= 1'b0;
			div_count <= 15'h0000;
		end else begin
			xtal_prev <= i_crystal_in_pin;
			if (i_crystal_in_pin && !xtal_prev) begin
				div_count <= div_count + 15'h0001;
			end
		end
	end

	assign tick = i_crystal_in_pin && !xtal_prev && (div_count == `RTC_XTAL_EDGES_PER_SEC);

	// freeze covers the whole host transaction, strobes included
	assign frozen = i_access_active || i_wr_strobe || i_rd_strobe;
	assign running = !regs[`RTC_ADDR_CTRL1][`RTC_BIT_STOP];
	assign apply = (tick || pending) && !frozen && running;

	// held-back second; a tick colliding with a release stays pending
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pending <= 1'b0;
		end else if (!running) begin
			pending <= 1'b0;
		end else if (frozen) begin
			pending <= pending || tick;
		end else begin
			pending <= pending && tick;
		end
	end

	// BCD carry chain, 24-hour counting
	always_comb begin
		c_sec = (regs[`RTC_ADDR_SEC][6:0] >= `RTC_SEC_LAST);
		next_sec = {regs[`RTC_ADDR_SEC][7], 1'b0, 6'h00};
		next_sec[6:0] = 7'(bcd_inc({1'b0, regs[`RTC_ADDR_SEC][6:0]},
			{1'b0, `RTC_SEC_LAST}, 8'h00));
		next_min = regs[`RTC_ADDR_MIN];
		next_hour = regs[`RTC_ADDR_HOUR];
		next_day = regs[`RTC_ADDR_DAY];
		next_wday = regs[`RTC_ADDR_WDAY];
		next_month = regs[`RTC_ADDR_MONTH];
		next_year = regs[`RTC_ADDR_YEAR];
		c_min = 1'b0;
		c_hour = 1'b0;
		c_day = 1'b0;
		c_month = 1'b0;
		if (c_sec) begin
			c_min = (regs[`RTC_ADDR_MIN] >= `RTC_MIN_LAST);
			next_min = bcd_inc(regs[`RTC_ADDR_MIN], `RTC_MIN_LAST, 8'h00);
		end
		if (c_min) begin
			c_hour = (regs[`RTC_ADDR_HOUR] >= `RTC_HOUR_LAST);
			next_hour = bcd_inc(regs[`RTC_ADDR_HOUR], `RTC_HOUR_LAST, 8'h00);
		end
		if (c_hour) begin
			c_day = (regs[`RTC_ADDR_DAY] >= month_last_day(regs[`RTC_ADDR_MONTH],
				regs[`RTC_ADDR_YEAR]));
			next_day = bcd_inc(regs[`RTC_ADDR_DAY],
				month_last_day(regs[`RTC_ADDR_MONTH], regs[`RTC_ADDR_YEAR]), 8'h01);
			next_wday = bcd_inc(regs[`RTC_ADDR_WDAY], `RTC_WDAY_LAST, 8'h00);
		end
		if (c_day) begin
			c_month = (regs[`RTC_ADDR_MONTH] >= `RTC_MONTH_LAST);
			next_month = bcd_inc(regs[`RTC_ADDR_MONTH], `RTC_MONTH_LAST, 8'h01);
		end
		if (c_month) begin
			next_year = bcd_inc(regs[`RTC_ADDR_YEAR], `RTC_YEAR_LAST, 8'h00);
		end
	end

	// register array: host writes, then counter advance when not frozen
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < `RTC_NUM_REGS; i++) begin
				regs[i] <= reset_value(5'(i));
			end
		end else if (i_wr_strobe && !i_ptr_load) begin
			regs[ptr] <= i_wr_data & impl_mask(ptr);
		end else if (apply) begin
			regs[`RTC_ADDR_SEC] <= next_sec;
			regs[`RTC_ADDR_MIN] <= next_min;
			regs[`RTC_ADDR_HOUR] <= next_hour;
			regs[`RTC_ADDR_DAY] <= next_day;
			regs[`RTC_ADDR_WDAY] <= next_wday;
			regs[`RTC_ADDR_MONTH] <= next_month;
			regs[`RTC_ADDR_YEAR] <= next_year;
		end
	end

	// read data, whole byte with dead bits forced low
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= 8'h00;
		end else if (i_rd_strobe && !i_ptr_load) begin
			o_rd_data <= regs[ptr] & impl_mask(ptr);
		end
	end

	// clock output and oscillator inverter, registered so the pin stays glitch free
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_divided_clock_pin <= 1'b0;
			o_divided_clock_oe <= 1'b0;
			o_crystal_out_pin <= 1'b0;
			o_seconds_tick <= 1'b0;
		end else begin
			o_divided_clock_pin <= i_clock_out_gate_input && i_crystal_in_pin;
			o_divided_clock_oe <= i_clock_out_gate_input;
			o_crystal_out_pin <= !i_crystal_in_pin;
			o_seconds_tick <= apply;
		end
	end

	// host pacing: one byte no faster than this many cycles, not checked here
	localparam int HOST_BYTE_CYCLES = `RTC_HOST_BYTE_CYCLES;

	a_ptr_advance: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(!i_ptr_load && (i_wr_strobe || i_rd_strobe) && ptr != `RTC_LAST_ADDR)
		|=> ptr == $past(ptr) + 5'h01)
		else $error("pointer did not advance by one");

	a_ptr_wrap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(!i_ptr_load && i_rd_strobe && ptr == `RTC_LAST_ADDR) |=> ptr == `RTC_FIRST_ADDR)
		else $error("pointer did not wrap to first address");

	a_ptr_load: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ptr_load && i_ptr_value <= `RTC_LAST_ADDR) |=> ptr == $past(i_ptr_value))
		else $error("pointer load not taken");

	a_freeze_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_access_active && !i_wr_strobe) |=> $stable(regs[`RTC_ADDR_SEC]))
		else $error("seconds moved while frozen");

	a_pending_catch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(pending && running && !frozen) |=> o_seconds_tick)
		else $error("held second not applied after release");

	a_pending_set: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(tick && frozen && running) |=> pending)
		else $error("second due while frozen was lost");

	a_freeze_strobe: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_rd_strobe && !i_wr_strobe) |=> $stable(regs[`RTC_ADDR_SEC]))
		else $error("seconds moved during a read");

	a_unimpl_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_rd_strobe && !i_ptr_load) |=> (o_rd_data & ~impl_mask($past(ptr))) == 8'h00)
		else $error("unimplemented bits read nonzero");

	a_ram_plain: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_wr_strobe && !i_ptr_load && ptr == `RTC_ADDR_RAM) |=> regs[`RTC_ADDR_RAM] == $past(i_wr_data))
		else $error("ram byte not stored");

	a_bcd_digit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_seconds_tick && $past(regs[`RTC_ADDR_SEC][3:0]) <= 4'h9 |-> regs[`RTC_ADDR_SEC][3:0] <= 4'h9)
		else $error("seconds units left BCD range");

	a_divided_clock_pin_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!i_clock_out_gate_input |=> !o_divided_clock_oe && !o_divided_clock_pin)
		else $error("clock output driven while gated off");

	a_divider_tick: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		tick |=> div_count == 15'h0000)
		else $error("divider did not roll over on tick");

	// writes wrap the pointer the same way reads do
	a_wr_wrap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(!i_ptr_load && i_wr_strobe && ptr == `RTC_LAST_ADDR) |=> ptr == `RTC_FIRST_ADDR)
		else $error("pointer did not wrap after a write");

	// weekday keeps only its three low bits, whatever the host sends
	a_wday_mask: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_wr_strobe && !i_ptr_load && ptr == `RTC_ADDR_WDAY)
		|=> regs[`RTC_ADDR_WDAY][7:3] == 5'h00)
		else $error("dead weekday bits stored");

	a_divided_clock_pin_on: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clock_out_gate_input |=> o_divided_clock_oe)
		else $error("clock output not enabled while gated on");

endmodule

// File: rtc_host_model.sv
// host-side model of the two-wire controller driving the byte port
`timescale 1ns/100ps
`include "rtc_cfg.svh"

module rtc_host_model #(
	parameter int BYTE_GAP = `RTC_HOST_BYTE_CYCLES
) (
	input wire logic i_clock,
	output logic o_access_active,
	output logic o_ptr_load,
	output logic [4:0] o_ptr_value,
	output logic o_wr_strobe,
	output logic [7:0] o_wr_data,
	output logic o_rd_strobe,
	input wire logic [7:0] i_rd_data
);
	// idle link: no transaction, strobes low
	initial begin
		o_access_active = 1'b0;
		o_ptr_load = 1'b0;
		o_ptr_value = 5'h00;
		o_wr_strobe = 1'b0;
		o_wr_data = 8'h00;
		o_rd_strobe = 1'b0;
	end

	// spacing between bytes bounds the link rate; BYTE_GAP falling edges, none if zero
	task automatic pace();
		repeat (BYTE_GAP) @(negedge i_clock);
	endtask

	// opens a transaction and sets the pointer; released data inverted
	task automatic load_ptr(input logic [4:0] a);
		pace();
		o_access_active = 1'b1;
		o_ptr_load = 1'b1;
		o_ptr_value = a;
		@(negedge i_clock);
		o_ptr_load = 1'b0;
		o_ptr_value = ~a;
	endtask

	task automatic write_byte(input logic [7:0] d);
		pace();
		o_wr_strobe = 1'b1;
		o_wr_data = d;
		@(negedge i_clock);
		o_wr_strobe = 1'b0;
		o_wr_data = ~d;
	endtask

	// read data is registered, so it is taken one edge after the strobe
	task automatic read_byte(output logic [7:0] d);
		pace();
		o_rd_strobe = 1'b1;
		@(negedge i_clock);
		o_rd_strobe = 1'b0;
		d = i_rd_data;
	endtask

	task automatic finish_access();
		@(negedge i_clock);
		o_access_active = 1'b0;
	endtask
endmodule

// File: rtc_register_access_tb_top.sv
// self-checking bench of the clock/calendar register bank
`timescale 1ns/100ps
`include "rtc_cfg.svh"

module rtc_register_access_tb_top
	import rtc_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n, access_active, ptr_load, wr_strobe, rd_strobe, crystal, gate;
	logic [4:0] ptr_value, ptr;
	logic [7:0] wr_data, rd_data;
	logic crystal_out, div_pin, div_oe, sec_tick;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	int ticks = 0;

	// 100 MHz system clock
	always #5 clock = ~clock;

	rtc_host_model #(.BYTE_GAP(8)) i_host (.i_clock(clock), .o_access_active(access_active),
		.o_ptr_load(ptr_load), .o_ptr_value(ptr_value), .o_wr_strobe(wr_strobe),
		.o_wr_data(wr_data), .o_rd_strobe(rd_strobe), .i_rd_data(rd_data));

	rtc_register_access i_dut (.i_clock(clock), .i_rst_n(rst_n),
		.i_access_active(access_active), .i_ptr_load(ptr_load), .i_ptr_value(ptr_value),
		.i_wr_strobe(wr_strobe), .i_wr_data(wr_data), .i_rd_strobe(rd_strobe),
		.o_rd_data(rd_data), .o_ptr(ptr), .i_crystal_in_pin(crystal),
		.o_crystal_out_pin(crystal_out), .i_clock_out_gate_input(gate),
		.o_divided_clock_pin(div_pin), .o_divided_clock_oe(div_oe), .o_seconds_tick(sec_tick));

	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check_byte(input string what, input rtc_byte_t exp, input rtc_byte_t got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	function automatic rtc_byte_t reset_val(input rtc_addr_t a);
		if (a == 5'h07 || a == 5'h09) return 8'h01;
		if (a >= 5'h0B && a <= 5'h0F) return 8'h80;
		return 8'h00;
	endfunction

	// implemented bits per address; the rest must read zero
	function automatic rtc_byte_t bit_mask(input rtc_addr_t a);
		case (a)
			5'h00: return 8'hB7;
			5'h01: return 8'hDF;
			5'h05: return 8'h7F;
			5'h06, 5'h07: return 8'h3F;
			5'h08: return 8'h07;
			5'h09, 5'h11: return 8'h1F;
			5'h0D, 5'h0E: return 8'hBF;
			5'h0F: return 8'h87;
			default: return 8'hFF;
		endcase
	endfunction

	// hang guard, sized for one crystal second plus register traffic
	always @(posedge clock) begin
		cycles++;
		if (cycles == 80000) begin
			fails++;
			conclude();
		end
	end

	always @(posedge clock) begin
		if (sec_tick === 1'b1) ticks++;
	end

	initial begin
		rtc_byte_t d;
		rtc_byte_t t_set[6] = '{8'h59, 8'h59, 8'h23, 8'h05, 8'h02, 8'h03};
		rtc_byte_t t_exp[6] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h03, 8'h03};
		rst_n = 1'b0;
		crystal = 1'b0;
		gate = 1'b0;
		repeat (20) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		// a plain load lands, an out-of-map one falls back to the first register
		i_host.load_ptr(5'h07);
		check_byte("pointer load", 8'h07, {3'b000, ptr});
		i_host.load_ptr(5'h1F);
		check_byte("pointer clamp", 8'h00, {3'b000, ptr});
		// whole-map burst: defaults, layout, stepping and wrap
		for (int a = 0; a < 18; a++) begin
			i_host.read_byte(d);
			check_byte("reset value", reset_val(5'(a)), d);
			check_byte("pointer step", (a == 17) ? 8'h00 : 8'(a + 1), {3'b000, ptr});
		end
		// all ones everywhere, then only implemented bits come back
		for (int a = 0; a < 18; a++) i_host.write_byte(8'hFF);
		for (int a = 0; a < 18; a++) begin
			i_host.read_byte(d);
			check_byte("masked byte", bit_mask(5'(a)), d);
		end
		// run the clock and preset a carry chain from seconds through to day and weekday
		i_host.load_ptr(5'h00);
		i_host.write_byte(8'h00);
		i_host.load_ptr(5'h04);
		for (int i = 0; i < 6; i++) i_host.write_byte(t_set[i]);
		// a full second of crystal while the access is still open
		for (int i = 0; i < 32768; i++) begin
			@(negedge clock) crystal = ~crystal;
			@(negedge clock) crystal = ~crystal;
		end
		repeat (10) @(negedge clock);
		check_byte("ticks while frozen", 8'h00, 8'(ticks));
		i_host.finish_access();
		for (int i = 0; i < 10 && ticks == 0; i++) @(negedge clock);
		check_byte("held tick", 8'h01, 8'(ticks));
		i_host.load_ptr(5'h04);
		for (int i = 0; i < 6; i++) begin
			i_host.read_byte(d);
			check_byte("bcd carry", t_exp[i], d);
		end
		i_host.finish_access();
		// clock output gating follows the gate input one cycle later
		gate = 1'b1;
		repeat (2) @(negedge clock);
		check_bit("clock oe on", 1'b1, div_oe);
		check_bit("crystal out", 1'b1, crystal_out);
		crystal = ~crystal;
		repeat (2) @(negedge clock);
		check_bit("clock pin high", 1'b1, div_pin);
		check_bit("crystal out low", 1'b0, crystal_out);
		gate = ~gate;
		repeat (2) @(negedge clock);
		check_bit("clock oe off", 1'b0, div_oe);
		check_bit("clock pin gated", 1'b0, div_pin);
		conclude();
	end
endmodule
